// ==== rtl/dac_cmd_pkg.sv ====
// constants, field layout and state type of the serial dual dac command decoder
// assumes one 16-bit word per chip-select frame, shifted in msb first
package dac_cmd_pkg;

  localparam int unsigned CMD_W      = 16;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned PD_POS     = 12;   // power_down_bit
  localparam int unsigned LE_POS     = 11;   // dac_load_enable_bit
  localparam int unsigned SRC_POS    = 10;   // load_source_bit
  localparam int unsigned SELB_POS   = 9;    // dac_b_select
  localparam int unsigned SELA_POS   = 8;    // dac_a_select
  localparam int unsigned DATA_MSB   = 7;    // data_msb
  localparam int unsigned DATA_LSB   = 0;    // data_lsb
  localparam int unsigned CODE_SPAN  = 256;  // output = scale * code / span

  localparam logic [CMD_W-1:0]  WORD_RST = 16'h0000;
  localparam logic [DATA_W-1:0] CODE_RST = 8'h00;
  localparam logic              PD_RST   = 1'b0;
  localparam logic              CS_IDLE  = 1'b1;
  localparam logic              STB_IDLE = 1'b1;

  typedef struct packed {
    logic [DATA_W-1:0] in_a;
    logic [DATA_W-1:0] in_b;
    logic [DATA_W-1:0] dac_a;
    logic [DATA_W-1:0] dac_b;
    logic              pd_a;
    logic              pd_b;
    logic              pending;
    logic              cs_prev;
    logic              stb_prev;
  } dec_state_t;

  localparam dec_state_t STATE_RST = '{
    in_a: CODE_RST, in_b: CODE_RST, dac_a: CODE_RST, dac_b: CODE_RST,
    pd_a: PD_RST, pd_b: PD_RST, pending: 1'b0,
    cs_prev: CS_IDLE, stb_prev: STB_IDLE};

endpackage

// ==== rtl/level_sync.sv ====
// two-flop synchroniser for one pin level into the system clock
// assumes the pin may change at any time relative to clk_sys
`timescale 1ns/1ps
module level_sync
  import dac_cmd_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic pin_level,
  output logic      level_sync_out
);

  typedef struct packed {
    logic meta;
    logic stable;
  } sync_state_t;

  sync_state_t st_d;
  sync_state_t st_q;

  // first stage feeds only the second
  always_comb begin
    st_d.meta   = pin_level;
    st_d.stable = st_q.meta;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '{meta: RST_VAL, stable: RST_VAL};
    end else begin
      st_q <= st_d;
    end
  end

  assign level_sync_out = st_q.stable;

endmodule // level_sync

// ==== rtl/link_shifter.sv ====
// serial-clock side of the link: 16-bit input shift register
// assumes the serial clock idles low and stops while chip select is high
`timescale 1ns/1ps
module link_shifter
  import dac_cmd_pkg::*;
(
  input  wire logic             serial_clk,
  input  wire logic             sys_rst,
  input  wire logic             cs_n,
  input  wire logic             serial_din,
  output logic      [CMD_W-1:0] shift_word
);

  typedef struct packed {
    logic [CMD_W-1:0] word;
  } shift_state_t;

  shift_state_t st_d;
  shift_state_t st_q;

  // msb arrives first; the last 16 bits before cs rise form the command
  always_comb begin
    st_d = st_q;
    if (!cs_n) begin
      st_d.word = {st_q.word[CMD_W-2:0], serial_din};
    end
  end

  // the word is held untouched between frames, so the system side can read it
  always_ff @(posedge serial_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '{word: WORD_RST};
    end else begin
      st_q <= st_d;
    end
  end

  assign shift_word = st_q.word;

endmodule // link_shifter

// ==== rtl/serial_dac_decoder.sv ====
// command decoder of a serial 8-bit dac family: one or two channels,
// with or without an asynchronous load strobe
// assumes the host keeps the serial clock still while chip select is high
`timescale 1ns/1ps
module serial_dac_decoder
  import dac_cmd_pkg::*;
#(
  parameter int unsigned NUM_CHANNELS = 2,  // 1 or 2
  parameter bit          HAS_STROBE   = 1'b1
) (
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire logic              serial_clk,
  input  wire logic              cs_n,
  input  wire logic              serial_din,
  input  wire logic              async_load_strobe,
  output logic      [DATA_W-1:0] dac_a_code,
  output logic      [DATA_W-1:0] dac_b_code,
  output logic                   dac_a_power_down,
  output logic                   dac_b_power_down,
  output logic                   load_pending
);

  // variant selection is fixed at elaboration
  localparam bit DUAL = (NUM_CHANNELS == 2);

  logic [CMD_W-1:0] shift_word;
  logic             cs_sync;
  logic             stb_sync;

  dec_state_t st_d;
  dec_state_t st_q;

  // link side on the serial clock
  link_shifter u_shifter (
    .serial_clk (serial_clk),
    .sys_rst    (sys_rst),
    .cs_n       (cs_n),
    .serial_din (serial_din),
    .shift_word (shift_word)
  );

  // chip select crosses as a level; its rise is the frame-end event
  level_sync #(.RST_VAL(CS_IDLE)) u_cs_sync (
    .clk_sys        (clk_sys),
    .sys_rst        (sys_rst),
    .pin_level      (cs_n),
    .level_sync_out (cs_sync)
  );

  // strobe is asynchronous to everything, so it is synchronised too
  level_sync #(.RST_VAL(STB_IDLE)) u_stb_sync (
    .clk_sys        (clk_sys),
    .sys_rst        (sys_rst),
    .pin_level      (async_load_strobe),
    .level_sync_out (stb_sync)
  );

  // channels addressed by a word; single variant ignores dac_b_select
  function automatic logic [1:0] addr_mask(input logic [CMD_W-1:0] w);
    logic [1:0] m;
    m = {w[SELB_POS], w[SELA_POS]};
    if (!DUAL) begin
      m[1] = 1'b0;
    end
    return m;
  endfunction

  // true when a word asks for a dac register transfer
  function automatic logic wants_update(input logic [CMD_W-1:0] w);
    logic u;
    u = 1'b0;
    if (w[LE_POS]) begin
      if (addr_mask(w) != 2'b00) begin
        u = 1'b1;
      end else if (!HAS_STROBE && DUAL) begin
        u = 1'b1;
      end else begin
        u = !w[PD_POS];
      end
    end
    return u;
  endfunction

  // true when the transfer waits for the strobe's falling edge
  function automatic logic wants_defer(input logic [CMD_W-1:0] w,
                                       input logic             stb_high);
    return HAS_STROBE && w[SRC_POS] && stb_high;
  endfunction

  // events seen on the system clock
  logic cmd_fire;
  logic stb_fall;
  logic [1:0] sel;
  logic [DATA_W-1:0] data_byte;
  logic do_update;
  logic do_defer;

  // cs rise is only seen after both sync flops, so the shift word is
  // long settled by then; the serial clock is idle while cs is high
  assign cmd_fire  = cs_sync && !st_q.cs_prev;
  assign stb_fall  = HAS_STROBE && !stb_sync && st_q.stb_prev;
  assign sel       = addr_mask(shift_word);
  assign data_byte = shift_word[DATA_MSB:DATA_LSB];
  assign do_update = cmd_fire && wants_update(shift_word);
  assign do_defer  = do_update && wants_defer(shift_word, stb_sync);

  // next-state for all decoder registers
  always_comb begin
    st_d          = st_q;
    st_d.cs_prev  = cs_sync;
    st_d.stb_prev = stb_sync;

    // a pending transfer fires on the strobe's fall, even when powered down
    if (st_q.pending && stb_fall) begin
      st_d.dac_a   = st_q.in_a;
      st_d.dac_b   = st_q.in_b;
      st_d.pending = 1'b0;
    end

    // unassigned words leave sel at zero and do_update low: no change
    if (cmd_fire) begin
      if (sel[0]) begin
        st_d.in_a = data_byte;
        st_d.pd_a = shift_word[PD_POS];
      end
      if (sel[1]) begin
        st_d.in_b = data_byte;
        st_d.pd_b = shift_word[PD_POS];
      end
      if (do_update && !do_defer) begin
        // both dacs take the freshly loaded inputs at once
        st_d.dac_a   = sel[0] ? data_byte : st_q.in_a;
        st_d.dac_b   = sel[1] ? data_byte : st_q.in_b;
        st_d.pending = 1'b0;
      end else if (do_defer) begin
        st_d.pending = 1'b1;
      end
    end

    // single variant keeps channel b at its reset state
    if (!DUAL) begin
      st_d.in_b  = CODE_RST;
      st_d.dac_b = CODE_RST;
      st_d.pd_b  = PD_RST;
    end
  end

  // power-on reset clears every code, power-down and pending register, so no init write is needed
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= STATE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // codes leave as plain unsigned binary for the ladder: out = ref*code/256
  assign dac_a_code       = st_q.dac_a;
  assign dac_b_code       = st_q.dac_b;
  assign dac_a_power_down = st_q.pd_a;
  assign dac_b_power_down = st_q.pd_b;
  assign load_pending     = st_q.pending;

  // checks on the system clock; they sit beside the logic so that a
  // variant change in the decode is caught where it is made
  default clocking cb_sys @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // building blocks: a decoded frame, its kind and the strobe release
  sequence s_cmd;
    cmd_fire;
  endsequence

  sequence s_pd_load_only;
    s_cmd ##0 (shift_word[PD_POS] && !shift_word[LE_POS]);
  endsequence

  sequence s_deferred;
    s_cmd ##0 do_defer;
  endsequence

  sequence s_strobe_release;
    (st_q.pending && stb_fall);
  endsequence

  sequence s_now_update;
    s_cmd ##0 (do_update && !do_defer);
  endsequence

  // nothing moves without a cs rise or a strobe fall
  a_quiet_no_change: assert property (
    (!cmd_fire && !(st_q.pending && stb_fall)) |=>
      ($stable(dac_a_code) && $stable(dac_b_code) &&
       $stable(st_q.in_a) && $stable(st_q.in_b) &&
       $stable(dac_a_power_down) && $stable(dac_b_power_down)))
    else $error("state changed without a command or strobe");

  // power-down load of a keeps both dac registers
  a_pd_load_a: assert property (
    (s_pd_load_only ##0 sel[0] && !(st_q.pending && stb_fall)) |=>
      (dac_a_power_down && st_q.in_a == $past(data_byte) &&
       $stable(dac_a_code) && $stable(dac_b_code)))
    else $error("power-down load of channel a wrong");

  // both addressed channels load and power down together
  a_pd_both_dual: assert property (
    (s_cmd ##0 DUAL && sel == 2'b11 && shift_word[PD_POS]) |=>
      (dac_a_power_down && dac_b_power_down &&
       st_q.in_a == $past(data_byte) && st_q.in_b == $past(data_byte)))
    else $error("dual power-down load wrong");

  // an immediate update leaves the dacs equal to the inputs
  a_update_now: assert property (
    (s_cmd ##0 do_update && !do_defer) |=>
      (dac_a_code == st_q.in_a && (!DUAL || dac_b_code == st_q.in_b) &&
       !load_pending))
    else $error("immediate dac update missing");

  a_strobe_low_now: assert property (
    (s_cmd ##0 HAS_STROBE && shift_word[SRC_POS] && !stb_sync && do_update)
      |=> (dac_a_code == st_q.in_a && !load_pending))
    else $error("strobe low at cs rise did not update at once");

  a_defer_hold: assert property (
    (s_deferred ##0 !(st_q.pending && stb_fall)) |=>
      (load_pending && $stable(dac_a_code) && $stable(dac_b_code)))
    else $error("deferred update did not wait");

  a_strobe_fire: assert property (
    (s_strobe_release ##0 !cmd_fire) |=>
      (dac_a_code == $past(st_q.in_a) && dac_b_code == $past(st_q.in_b) &&
       !load_pending))
    else $error("strobe fall did not transfer inputs");

  a_no_le_dacs_kept: assert property (
    (s_cmd ##0 !HAS_STROBE && !shift_word[LE_POS]) |=>
      ($stable(dac_a_code) && $stable(dac_b_code)))
    else $error("dac changed with load disabled");

  a_no_strobe_addr0: assert property (
    (s_cmd ##0 !HAS_STROBE && DUAL && sel == 2'b00 && shift_word[LE_POS])
      |=> (dac_a_code == st_q.in_a && dac_b_code == st_q.in_b &&
           $stable(st_q.in_a) && $stable(st_q.in_b)))
    else $error("broadcast transfer without strobe wrong");

  a_single_xfer: assert property (
    (s_cmd ##0 !DUAL && !shift_word[SELA_POS] && shift_word[LE_POS] &&
     !shift_word[PD_POS] && !do_defer) |=>
      ($stable(st_q.in_a) && dac_a_code == st_q.in_a))
    else $error("single transfer altered input or missed dac");

  a_unassigned_idle: assert property (
    (s_cmd ##0 sel == 2'b00 && !do_update && !(st_q.pending && stb_fall))
      |=> ($stable(dac_a_code) && $stable(dac_b_code) &&
           $stable(dac_a_power_down) && $stable(dac_b_power_down) &&
           $stable(st_q.in_a) && $stable(st_q.in_b) && $stable(load_pending)))
    else $error("unassigned command changed state");

  a_single_b_idle: assert property (
    !DUAL |-> (dac_b_code == CODE_RST && !dac_b_power_down))
    else $error("single variant moved channel b");

  // power-down load of channel b mirrors channel a
  a_pd_load_b: assert property (
    (s_pd_load_only ##0 sel[1] && !(st_q.pending && stb_fall)) |=>
      (dac_b_power_down && st_q.in_b == $past(data_byte) &&
       $stable(dac_a_code) && $stable(dac_b_code)))
    else $error("power-down load of channel b wrong");

  // a power-down load addressed to a alone must not touch channel b
  a_pd_other_kept: assert property (
    (s_pd_load_only ##0 sel == 2'b01) |=>
      ($stable(st_q.in_b) && $stable(dac_b_power_down)))
    else $error("power-down load of a disturbed channel b");

  // power-down with an immediate update still moves both dac registers
  a_pd_update_now: assert property (
    (s_now_update ##0 shift_word[PD_POS] && sel[0]) |=>
      (dac_a_power_down && dac_a_code == $past(data_byte) &&
       (!DUAL || dac_b_code == st_q.in_b)))
    else $error("power-down update of channel a wrong");

  // a deferred transfer is armed even though the channel is powered down
  a_defer_while_down: assert property (
    (s_deferred ##0 shift_word[PD_POS] && sel[0]) |=>
      (dac_a_power_down && load_pending))
    else $error("deferred transfer lost on power-down");

  // a command without a transfer leaves a waiting transfer alone
  a_pending_kept: assert property (
    (s_cmd ##0 !do_update && !(st_q.pending && stb_fall)) |=>
      $stable(load_pending))
    else $error("pending transfer changed by a non-update command");

  // without a strobe the source bit is ignored and nothing waits
  a_no_strobe_update: assert property (
    (s_now_update ##0 !HAS_STROBE) |=>
      (dac_a_code == st_q.in_a && dac_b_code == st_q.in_b &&
       !load_pending))
    else $error("update without strobe did not happen at once");

  // single channel: a_select with power-down loads and powers down
  a_single_pd_load: assert property (
    (s_cmd ##0 !DUAL && shift_word[SELA_POS] && shift_word[PD_POS]) |=>
      (dac_a_power_down && st_q.in_a == $past(data_byte)))
    else $error("single power-down load wrong");

  // single channel: power-down without a_select is an unassigned word
  a_single_pd_ignored: assert property (
    (s_cmd ##0 !DUAL && !shift_word[SELA_POS] && shift_word[PD_POS] &&
     !(st_q.pending && stb_fall)) |=>
      ($stable(dac_a_code) && $stable(st_q.in_a) &&
       $stable(dac_a_power_down)))
    else $error("single unassigned power-down word acted");

  // a cleared power-down bit on an addressed channel powers it up
  a_powerup_mode: assert property (
    (s_cmd ##0 sel[0] && !shift_word[PD_POS]) |=> !dac_a_power_down)
    else $error("addressed channel stayed powered down");

  // while the frame is open no input register or power state may move
  a_frame_quiet: assert property (
    !cs_sync |=>
      ($stable(st_q.in_a) && $stable(st_q.in_b) &&
       $stable(dac_a_power_down) && $stable(dac_b_power_down)))
    else $error("register moved while chip select was low");

  // the data byte reaches the dac register bit for bit, unsigned
  a_data_straight: assert property (
    (s_now_update ##0 sel[0]) |=>
      (dac_a_code == $past(shift_word[DATA_MSB:DATA_LSB])))
    else $error("dac a code differs from the data byte");

  // channel b takes its byte on an immediate dual update
  a_dual_b_update: assert property (
    (s_now_update ##0 DUAL && sel[1]) |=>
      (dac_b_code == $past(data_byte) && !load_pending))
    else $error("dac b not updated at once");

  // single channel with the strobe high waits for its fall
  a_single_defer: assert property (
    (s_deferred ##0 !DUAL) |=>
      (load_pending && $stable(dac_a_code)))
    else $error("single deferred transfer did not wait");

endmodule // serial_dac_decoder

// ==== sim/spi_host_model.sv ====
// host side of the serial link: mode-0 word sender for the dac decoder
// assumes the caller starts a word only while chip select is idle
`timescale 1ns/1ps
module spi_host_model
  import dac_cmd_pkg::*;
(
  output logic serial_clk,
  output logic cs_n,
  output logic serial_din
);
  localparam int HALF_NS = 32;  // 64 ns link period

  // link idles with clock low and chip select high
  initial begin
    serial_clk = 1'b0;
    cs_n       = CS_IDLE;
    serial_din = 1'b1;
  end

  // one 16-bit word, msb first; data moves at cs fall and then only on falling clock edges
  task automatic send(input logic [CMD_W-1:0] word);
    int i;
    #5;
    cs_n       = 1'b0;
    serial_din = word[CMD_W-1];
    #HALF_NS;
    for (i = CMD_W - 1; i >= 0; i--) begin
      serial_clk = 1'b1;
      #HALF_NS;
      serial_clk = 1'b0;
      // released line shows the inverse so a stale bit is never read
      serial_din = (i > 0) ? word[i-1] : ~word[0];
      #HALF_NS;
    end
    cs_n = CS_IDLE;  // clock stays still from here on
  endtask
endmodule  // spi_host_model

// ==== sim/serial_dual_dac_command_decoder_test.sv ====
// self-checking bench of the dual dac decoder with load strobe
// assumes the host model drives the link; strobe and reset come from here
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin fails++; \
  $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module serial_dual_dac_command_decoder_test
  import dac_cmd_pkg::*;
;
  typedef struct packed {
    logic [DATA_W-1:0] a;
    logic [DATA_W-1:0] b;
    logic              pda;
    logic              pdb;
    logic              pend;
  } note_t;

  logic              clk_sys = 1'b0;
  logic              sys_rst;
  logic              serial_clk;
  logic              cs_n;
  logic              serial_din;
  logic              async_load_strobe;
  logic [DATA_W-1:0] dac_a_code;
  logic [DATA_W-1:0] dac_b_code;
  logic              dac_a_power_down;
  logic              dac_b_power_down;
  logic              load_pending;
  logic [DATA_W-1:0] m_in_a, m_in_b, m_dac_a, m_dac_b;
  logic              m_pda, m_pdb, m_pend;
  note_t             notes[$];
  note_t             n;
  event              result_ev;
  int                fails;
  int                samples_checked;
  int                seed;

  spi_host_model host_u (
    .serial_clk (serial_clk),
    .cs_n       (cs_n),
    .serial_din (serial_din)
  );

  serial_dac_decoder #(
    .NUM_CHANNELS (2),
    .HAS_STROBE   (1'b1)
  ) dut_u (
    .clk_sys           (clk_sys),
    .sys_rst           (sys_rst),
    .serial_clk        (serial_clk),
    .cs_n              (cs_n),
    .serial_din        (serial_din),
    .async_load_strobe (async_load_strobe),
    .dac_a_code        (dac_a_code),
    .dac_b_code        (dac_b_code),
    .dac_a_power_down  (dac_a_power_down),
    .dac_b_power_down  (dac_b_power_down),
    .load_pending      (load_pending)
  );

  // two of the other three variants share the link so their own checks see traffic
  serial_dac_decoder #(
    .NUM_CHANNELS (2),
    .HAS_STROBE   (1'b0)
  ) dut_nostb_u (
    .clk_sys           (clk_sys),
    .sys_rst           (sys_rst),
    .serial_clk        (serial_clk),
    .cs_n              (cs_n),
    .serial_din        (serial_din),
    .async_load_strobe (async_load_strobe),
    .dac_a_code        (),
    .dac_b_code        (),
    .dac_a_power_down  (),
    .dac_b_power_down  (),
    .load_pending      ()
  );

  serial_dac_decoder #(
    .NUM_CHANNELS (1),
    .HAS_STROBE   (1'b1)
  ) dut_single_u (
    .clk_sys           (clk_sys),
    .sys_rst           (sys_rst),
    .serial_clk        (serial_clk),
    .cs_n              (cs_n),
    .serial_din        (serial_din),
    .async_load_strobe (async_load_strobe),
    .dac_a_code        (),
    .dac_b_code        (),
    .dac_a_power_down  (),
    .dac_b_power_down  (),
    .load_pending      ()
  );

  always #20 clk_sys = ~clk_sys;

  // record the expectation, then let the worst-case answer latency pass
  task automatic note_now;
    notes.push_back(note_t'{m_dac_a, m_dac_b, m_pda, m_pdb, m_pend});
    repeat (6) @(posedge clk_sys);
    #1;
    -> result_ev;
  endtask

  task automatic xfer;
    m_dac_a = m_in_a;
    m_dac_b = m_in_b;
    m_pend  = 1'b0;
  endtask

  // strobe is settled well before the frame so the sampled level is known
  task automatic run_cmd(input logic [4:0] ctl, input logic stb);
    logic [31:0]       r;
    logic [CMD_W-1:0]  w;
    logic              sa, sb;
    r = $random(seed);
    w = {r[2:0], ctl, r[15:8]};
    if (async_load_strobe && !stb && m_pend) xfer();
    async_load_strobe = stb;
    repeat (4) @(posedge clk_sys);
    #1;
    host_u.send(w);
    sa = w[SELA_POS];
    sb = w[SELB_POS];
    if (sa) begin
      m_in_a = w[DATA_MSB:DATA_LSB];
      m_pda  = w[PD_POS];
    end
    if (sb) begin
      m_in_b = w[DATA_MSB:DATA_LSB];
      m_pdb  = w[PD_POS];
    end
    // address 00 with power-down set is unassigned and must do nothing
    if (w[LE_POS] && (sa || sb || !w[PD_POS])) begin
      if (w[SRC_POS] && stb) m_pend = 1'b1;
      else xfer();
    end
    note_now();
  endtask

  // a strobe fall fires a waiting transfer; without one it is ignored
  task automatic fall_strobe;
    if (!async_load_strobe) begin
      async_load_strobe = 1'b1;
      repeat (4) @(posedge clk_sys);
      #1;
    end
    async_load_strobe = 1'b0;
    if (m_pend) xfer();
    note_now();
    async_load_strobe = 1'b1;
    @(posedge clk_sys);
    #1;
  endtask

  // mid-run reset must clear every register again, a waiting transfer too
  task automatic pulse_reset;
    sys_rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    {m_in_a, m_in_b, m_dac_a, m_dac_b} = '0;
    {m_pda, m_pdb, m_pend} = '0;
    note_now();
  endtask

  // watcher: each announced result is held against the oldest note
  always @(result_ev) begin
    n = notes.pop_front();
    `CHK("dac_a_code", n.a, dac_a_code)
    `CHK("dac_b_code", n.b, dac_b_code)
    `CHK("dac_a_power_down", n.pda, dac_a_power_down)
    `CHK("dac_b_power_down", n.pdb, dac_b_power_down)
    `CHK("load_pending", n.pend, load_pending)
  end

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // roughly 40 cycles per command; the limit leaves wide margin
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    conclude();
  end

  // every control combination, first with the strobe high, then random
  initial begin
    logic [31:0] r;
    seed = 36;
    fails = 0;
    samples_checked = 0;
    sys_rst = 1'b1;
    async_load_strobe = STB_IDLE;
    {m_in_a, m_in_b, m_dac_a, m_dac_b} = '0;
    {m_pda, m_pdb, m_pend} = '0;
    repeat (2) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    note_now();
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 32; c++) begin
        r = $random(seed);
        run_cmd(c[4:0], (p == 0) | r[4]);
        if (r[9]) fall_strobe();
      end
      if (p == 0) pulse_reset();
    end
    fall_strobe();
    conclude();
  end
endmodule  // serial_dual_dac_command_decoder_test
